// >>> interrupt_flag_status_bank.sv
// interrupt flag status bank: two 16-bit sticky flag registers behind axi4-lite
// assumes event inputs are synchronous one-cycle pulses on clock
// Operation
// - a source event sets its flag to 1 and the flag holds until changed.
// - a flag reading 0 means no event was recorded since it was last cleared.
// - every implemented flag bit is software readable and writable, writes store directly.
// - all implemented flags are 0 after reset.
// - unimplemented bits read 0 and ignore writes.
// - first register bit 15 holds the pwm one fault a flag.
// - first register bit 10 holds the encoder event flag, set by an encoder event.
// - second register bit 10 holds the pwm two fault a flag.
// - second register bit 9 holds the pwm two error flag, reporting an event.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`default_nettype none
module interrupt_flag_status_bank
    import flag_bank_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // write address channel
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // write data channel
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // write response channel
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // read address channel
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // read data channel
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // peripheral events and flag view
    input wire flag_bank_pkg::event_t events,
    output flag_bank_pkg::flags_t flags
);
    import flag_bank_pkg::*;

    logic [15:0] motor_flags_ff;
    logic [15:0] pwm2_flags_ff;
    logic aw_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic w_held_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_write;
    logic wr_motor;
    logic wr_pwm2;
    logic [15:0] nxt_motor_flags;
    logic [15:0] nxt_pwm2_flags;
    logic [15:0] motor_set;
    logic [15:0] pwm2_set;

    // byte-lane merge of the low half-word; only implemented bits survive
    function automatic logic [15:0] merge_write(input logic [15:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb,
                                                input logic [15:0] mask);
        logic [15:0] m;
        m = old;
        if (strb[0]) begin
            m[7:0] = data[7:0];
        end
        if (strb[1]) begin
            m[15:8] = data[15:8];
        end
        merge_write = m & mask;
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        addr_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // write address and data accepted in either order, response after both
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_motor = do_write && addr_hit(aw_addr_ff, OFS_MOTOR_FLAGS);
    assign wr_pwm2 = do_write && addr_hit(aw_addr_ff, OFS_PWM2_FLAGS);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            w_held_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_motor || wr_pwm2) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // event set vectors placed at their bit positions
    always_comb begin
        motor_set = 16'h0000;
        pwm2_set = 16'h0000;
        motor_set[POS_PWM_ONE_FAULT_A] = events.pwm_one_fault_a;
        motor_set[POS_ENCODER_EVENT] = events.encoder_event;
        motor_set[POS_PWM_ONE_ERROR] = events.pwm_one_error;
        pwm2_set[POS_PWM_TWO_FAULT_A] = events.pwm_two_fault_a;
        pwm2_set[POS_PWM_TWO_ERROR] = events.pwm_two_error;
        pwm2_set[POS_UART_ONE_ERROR] = events.uart_one_error;
    end

    // set wins over a software clear in the same cycle so no event is lost
    always_comb begin
        nxt_motor_flags = motor_flags_ff;
        nxt_pwm2_flags = pwm2_flags_ff;
        if (wr_motor) begin
            nxt_motor_flags = merge_write(motor_flags_ff, w_data_ff, w_strb_ff,
                                          MASK_MOTOR_FLAGS);
        end
        if (wr_pwm2) begin
            nxt_pwm2_flags = merge_write(pwm2_flags_ff, w_data_ff, w_strb_ff,
                                         MASK_PWM2_FLAGS);
        end
        nxt_motor_flags = nxt_motor_flags | (motor_set & MASK_MOTOR_FLAGS);
        nxt_pwm2_flags = nxt_pwm2_flags | (pwm2_set & MASK_PWM2_FLAGS);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            motor_flags_ff <= RST_MOTOR_FLAGS;
            pwm2_flags_ff <= RST_PWM2_FLAGS;
        end else begin
            motor_flags_ff <= nxt_motor_flags;
            pwm2_flags_ff <= nxt_pwm2_flags;
        end
    end

    assign flags.motor_fault_encoder_flags = motor_flags_ff;
    assign flags.pwm2_uart_error_flags = pwm2_flags_ff;

    // read path: one read at a time, answer one cycle after address
    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            if (addr_hit(s_axi_araddr, OFS_MOTOR_FLAGS)) begin
                rdata_ff <= {16'h0000, motor_flags_ff & MASK_MOTOR_FLAGS};
                rresp_ff <= RESP_OKAY;
            end else if (addr_hit(s_axi_araddr, OFS_PWM2_FLAGS)) begin
                rdata_ff <= {16'h0000, pwm2_flags_ff & MASK_PWM2_FLAGS};
                rresp_ff <= RESP_OKAY;
            end else begin
                rdata_ff <= '0;
                rresp_ff <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // assertions
    property p_event_sets;
        @(posedge clock) disable iff (!rst_n)
        events.encoder_event |=> motor_flags_ff[POS_ENCODER_EVENT];
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("encoder event not flagged");

    property p_fault_sets;
        @(posedge clock) disable iff (!rst_n)
        events.pwm_one_fault_a |=> motor_flags_ff[POS_PWM_ONE_FAULT_A];
    endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("fault a one not flagged");

    property p_err1_sets;
        @(posedge clock) disable iff (!rst_n)
        events.pwm_one_error |=> motor_flags_ff[POS_PWM_ONE_ERROR];
    endproperty
    a_err1_sets: assert property (p_err1_sets) else $error("pwm one error not flagged");

    property p_fault2_sets;
        @(posedge clock) disable iff (!rst_n)
        events.pwm_two_fault_a |=> pwm2_flags_ff[POS_PWM_TWO_FAULT_A];
    endproperty
    a_fault2_sets: assert property (p_fault2_sets) else $error("fault a two not flagged");

    property p_err2_sets;
        @(posedge clock) disable iff (!rst_n)
        events.pwm_two_error |=> pwm2_flags_ff[POS_PWM_TWO_ERROR];
    endproperty
    a_err2_sets: assert property (p_err2_sets) else $error("pwm two error not flagged");

    property p_uart_sets;
        @(posedge clock) disable iff (!rst_n)
        events.uart_one_error |=> pwm2_flags_ff[POS_UART_ONE_ERROR];
    endproperty
    a_uart_sets: assert property (p_uart_sets) else $error("uart error not flagged");

    property p_sticky;
        @(posedge clock) disable iff (!rst_n)
        (motor_flags_ff[POS_ENCODER_EVENT] && !wr_motor) |=> motor_flags_ff[POS_ENCODER_EVENT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without write");

    property p_no_spurious;
        @(posedge clock) disable iff (!rst_n)
        (!pwm2_flags_ff[POS_UART_ONE_ERROR] && !wr_pwm2 && !events.uart_one_error)
            |=> !pwm2_flags_ff[POS_UART_ONE_ERROR];
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("flag rose without cause");

    property p_write_stores;
        @(posedge clock) disable iff (!rst_n)
        (wr_motor && w_strb_ff[1] && !events.pwm_one_fault_a)
            |=> motor_flags_ff[POS_PWM_ONE_FAULT_A] == $past(w_data_ff[POS_PWM_ONE_FAULT_A]);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("write not stored");

    property p_unimpl_zero;
        @(posedge clock) disable iff (!rst_n)
        ((motor_flags_ff & ~MASK_MOTOR_FLAGS) == 16'h0000)
            && ((pwm2_flags_ff & ~MASK_PWM2_FLAGS) == 16'h0000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    property p_reset_clear;
        @(posedge clock) !rst_n |=> (motor_flags_ff == 16'h0000) && (pwm2_flags_ff == 16'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("flags not cleared by reset");

    property p_motor_sticky;
        @(posedge clock) disable iff (!rst_n)
        !wr_motor |=> (motor_flags_ff & $past(motor_flags_ff)) == $past(motor_flags_ff);
    endproperty
    a_motor_sticky: assert property (p_motor_sticky) else $error("motor flag lost");

    property p_pwm2_sticky;
        @(posedge clock) disable iff (!rst_n)
        !wr_pwm2 |=> (pwm2_flags_ff & $past(pwm2_flags_ff)) == $past(pwm2_flags_ff);
    endproperty
    a_pwm2_sticky: assert property (p_pwm2_sticky) else $error("pwm2 flag lost");

    // no write and no event: nothing may move in either direction
    property p_motor_quiet;
        @(posedge clock) disable iff (!rst_n)
        (!wr_motor && !events.pwm_one_fault_a && !events.encoder_event && !events.pwm_one_error)
            |=> $stable(motor_flags_ff);
    endproperty
    a_motor_quiet: assert property (p_motor_quiet) else $error("motor flag moved");

    property p_pwm2_quiet;
        @(posedge clock) disable iff (!rst_n)
        (!wr_pwm2 && !events.pwm_two_fault_a && !events.pwm_two_error && !events.uart_one_error)
            |=> $stable(pwm2_flags_ff);
    endproperty
    a_pwm2_quiet: assert property (p_pwm2_quiet) else $error("pwm2 flag moved");

    // read data is the register as it stood when the address was taken
    property p_read_motor;
        @(posedge clock) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, OFS_MOTOR_FLAGS))
            |=> s_axi_rvalid && (s_axi_rdata == {16'h0000, $past(motor_flags_ff)});
    endproperty
    a_read_motor: assert property (p_read_motor) else $error("motor read data wrong");

    property p_read_pwm2;
        @(posedge clock) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, OFS_PWM2_FLAGS))
            |=> s_axi_rvalid && (s_axi_rdata == {16'h0000, $past(pwm2_flags_ff)});
    endproperty
    a_read_pwm2: assert property (p_read_pwm2) else $error("pwm2 read data wrong");

    property p_upper_zero;
        @(posedge clock) disable iff (!rst_n)
        s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_unmapped_read;
        @(posedge clock) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && !addr_hit(s_axi_araddr, OFS_MOTOR_FLAGS)
            && !addr_hit(s_axi_araddr, OFS_PWM2_FLAGS))
            |=> (s_axi_rresp == RESP_SLVERR) && (s_axi_rdata == 32'h0000_0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("stray read");

    property p_unmapped_write;
        @(posedge clock) disable iff (!rst_n)
        (do_write && !wr_motor && !wr_pwm2 && (events == '0))
            |=> $stable(motor_flags_ff) && $stable(pwm2_flags_ff)
            && (s_axi_bresp == RESP_SLVERR);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("stray write");

    property p_write_okay;
        @(posedge clock) disable iff (!rst_n)
        (wr_motor || wr_pwm2) |=> s_axi_bvalid && (s_axi_bresp == RESP_OKAY);
    endproperty
    a_write_okay: assert property (p_write_okay) else $error("write not answered");

    property p_low_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_pwm2 && w_strb_ff[0] && !events.uart_one_error)
            |=> pwm2_flags_ff[POS_UART_ONE_ERROR] == $past(w_data_ff[POS_UART_ONE_ERROR]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("uart write lost");

    c_write_done: cover property (@(posedge clock) disable iff (!rst_n) do_write);
    c_read_done: cover property (@(posedge clock) disable iff (!rst_n)
        s_axi_rvalid && s_axi_rready);
    c_set_vs_clear: cover property (@(posedge clock) disable iff (!rst_n)
        wr_motor && events.encoder_event);
    c_unmapped: cover property (@(posedge clock) disable iff (!rst_n)
        do_write && !wr_motor && !wr_pwm2);
    c_all_events: cover property (@(posedge clock) disable iff (!rst_n) events == '1);
endmodule
`default_nettype wire

// >>> flag_bank_pkg.sv
// package for the interrupt flag status bank: offsets, bit positions, masks, bus types
// assumes a 32-bit axi4-lite register bus and a single system clock
`default_nettype none
package flag_bank_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_MOTOR_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PWM2_FLAGS = 4'h4;
    localparam logic [15:0] RST_MOTOR_FLAGS = 16'h0000;
    localparam logic [15:0] RST_PWM2_FLAGS = 16'h0000;
    // first register bit positions
    localparam int POS_PWM_ONE_FAULT_A = 15;
    localparam int POS_ENCODER_EVENT = 10;
    localparam int POS_PWM_ONE_ERROR = 9;
    // second register bit positions
    localparam int POS_PWM_TWO_FAULT_A = 10;
    localparam int POS_PWM_TWO_ERROR = 9;
    localparam int POS_UART_ONE_ERROR = 1;
    localparam logic [15:0] MASK_MOTOR_FLAGS = 16'h8600;
    localparam logic [15:0] MASK_PWM2_FLAGS = 16'h0602;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // peripheral event pulses, one cycle each
    typedef struct packed {
        logic pwm_one_fault_a;
        logic encoder_event;
        logic pwm_one_error;
        logic pwm_two_fault_a;
        logic pwm_two_error;
        logic uart_one_error;
    } event_t;

    typedef struct packed {
        logic [15:0] motor_fault_encoder_flags;
        logic [15:0] pwm2_uart_error_flags;
    } flags_t;
endpackage
`default_nettype wire

// >>> tb_interrupt_flag_status_bank.sv
// self-checking bench for the interrupt flag status bank
// assumes flag_bank_pkg is compiled first; drives axi4-lite and event pulses itself
`default_nettype none
module tb_interrupt_flag_status_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import flag_bank_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
    logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp;
    event_t events = '0;
    flags_t flags;
    int num_errors = 0;
    int comparisons = 0;
    logic [15:0] exp0 [6] = '{16'h8000, 16'h0400, 16'h0200, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] exp1 [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0400, 16'h0200, 16'h0002};

    always #5 clock = ~clock;

    interrupt_flag_status_bank dut_u (
        .clock(clock), .rst_n(rst_n),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .events(events), .flags(flags)
    );

    task automatic end_sim();
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            num_errors++;
        end
    endtask

    // a hung handshake counts as a mismatch and closes the run
    task automatic timed_out(input int n);
        if (n >= 50) begin
            $display("ERROR handshake expected response seen timeout");
            num_errors++;
            end_sim();
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        int n;
        logic ad;
        logic wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        while (!(ad && wd) && n < 50) begin
            @(posedge clock);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        timed_out(n);
        n = 0;
        while (!bvalid && n < 50) begin
            @(posedge clock);
            n++;
        end
        timed_out(n);
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
        @(posedge clock);
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (!arready && n < 50);
        timed_out(n);
        arvalid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!rvalid && n < 50);
        timed_out(n);
        rready <= 1'b0;
        check("rdata", rdata, ed);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        @(posedge clock);
    endtask

    task automatic clear_both();
        axi_write(OFS_MOTOR_FLAGS, 32'h0, 4'hf, RESP_OKAY);
        axi_write(OFS_PWM2_FLAGS, 32'h0, 4'hf, RESP_OKAY);
    endtask

    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check("flags after reset", flags, 32'h0);
        axi_read(OFS_MOTOR_FLAGS, 32'h0, RESP_OKAY);
        axi_read(OFS_PWM2_FLAGS, 32'h0, RESP_OKAY);
        // all ones: only implemented bits stick, upper lanes ignored
        axi_write(OFS_MOTOR_FLAGS, 32'hffffffff, 4'hf, RESP_OKAY);
        axi_read(OFS_MOTOR_FLAGS, {16'h0, MASK_MOTOR_FLAGS}, RESP_OKAY);
        axi_write(OFS_PWM2_FLAGS, 32'hffffffff, 4'hf, RESP_OKAY);
        axi_read(OFS_PWM2_FLAGS, {16'h0, MASK_PWM2_FLAGS}, RESP_OKAY);
        check("flags view", flags, {MASK_MOTOR_FLAGS, MASK_PWM2_FLAGS});
        clear_both();
        axi_read(OFS_MOTOR_FLAGS, 32'h0, RESP_OKAY);
        // byte lanes: low lane holds no flag of the first register
        axi_write(OFS_MOTOR_FLAGS, 32'h0000ffff, 4'h1, RESP_OKAY);
        axi_read(OFS_MOTOR_FLAGS, 32'h0, RESP_OKAY);
        axi_write(OFS_MOTOR_FLAGS, 32'h0000ffff, 4'h2, RESP_OKAY);
        axi_read(OFS_MOTOR_FLAGS, {16'h0, MASK_MOTOR_FLAGS}, RESP_OKAY);
        // unmapped word
        axi_write(4'h8, 32'hffffffff, 4'hf, RESP_SLVERR);
        axi_read(4'h8, 32'h0, RESP_SLVERR);
        check("flags unmapped", flags, {MASK_MOTOR_FLAGS, 16'h0000});
        // each source alone sets only its own flag, which then sticks
        for (int i = 0; i < 6; i++) begin
            clear_both();
            events <= event_t'(6'h20 >> i);
            @(posedge clock);
            events <= '0;
            repeat (4) @(posedge clock);
            check("flags event", flags, {exp0[i], exp1[i]});
            axi_read(OFS_MOTOR_FLAGS, {16'h0, exp0[i]}, RESP_OKAY);
            axi_read(OFS_PWM2_FLAGS, {16'h0, exp1[i]}, RESP_OKAY);
        end
        // an event in the cycle of a clearing write still lands
        fork
            axi_write(OFS_MOTOR_FLAGS, 32'h0, 4'hf, RESP_OKAY);
            begin
                @(posedge clock);
                events <= event_t'(6'h10);
                @(posedge clock);
                events <= '0;
            end
        join
        axi_read(OFS_MOTOR_FLAGS, {16'h0, exp0[1]}, RESP_OKAY);
        // second reset in mid-run clears stored flags
        events <= '1;
        @(posedge clock);
        events <= '0;
        @(posedge clock);
        check("flags all events", flags, {MASK_MOTOR_FLAGS, MASK_PWM2_FLAGS});
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check("flags after second reset", flags, 32'h0);
        axi_read(OFS_MOTOR_FLAGS, 32'h0, RESP_OKAY);
        axi_read(OFS_PWM2_FLAGS, 32'h0, RESP_OKAY);
        end_sim();
    end
endmodule
`default_nettype wire
